// >>> acc_top.sv
// comparator control, status, input selection and register slave
//
// Function
// - Mux enable set, converter off: negative input is channel hi*8+lo.
// - Mux enable clear or converter on: negative input is the pin.
// - Power-off bit 7 removes comparator power; it may be set anytime.
// - Bandgap bit 6 puts the bandgap on the positive input, else pin.
// - Output bit 5 shows the synced comparator, one to two cycles late.
// - Event flag bit 4 sets on a matching transition, enabled or not.
// - The flag clears on vector execution or a written one, not a zero.
// - Request is high while flag, enable bit 3 and global enable hold.
// - Edge mode 00 toggle, 01 reserved, 10 falling, 11 rising.
// - Capture bit 2 feeds the output to the timer capture front end.
// - A pin input-disable bit turns off its buffer, port bit reads 0.
// - Conv b: channel high at 3, mux enable at 6, bits 7,5,4 read 0.
// - Comparator output is high when positive input exceeds negative.
`timescale 1ns/1ps
module acc_top (
	// clock and reset
	input  wire logic        clk,
	input  wire logic        sys_rst,
	// avalon-mm slave
	input  wire logic [9:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	output logic [31:0]      avs_readdata,
	output logic             avs_waitrequest,
	// converter state from outside
	input  wire logic        converter_on,
	input  wire logic [2:0]  channel_select_low,
	// analog core
	input  wire logic        comparator_raw,
	output logic             comparator_power_off,
	output logic             bandgap_positive_select,
	output logic             neg_use_channel,
	output logic [3:0]       neg_channel,
	// pins
	input  wire logic        negative_pin_raw,
	input  wire logic        positive_pin_raw,
	output logic             negative_pin_input_off,
	output logic             positive_pin_input_off,
	output logic             negative_pin_port_bit,
	output logic             positive_pin_port_bit,
	// timer capture front end
	output logic             capture_source,
	output logic             capture_route_active,
	// cpu interrupt
	input  wire logic        global_irq_enable,
	input  wire logic        irq_vector_ack,
	output logic             comparator_irq,
	output logic             event_irq
);
	// register state
	logic [7:0]  ctrl_reg, ctrl_next;
	logic [7:0]  convb_reg, convb_next;
	logic [7:0]  pins_reg, pins_next;
	logic        flag_reg, flag_next;
	logic        prev_reg, prev_next;
	logic [1:0]  evt_reg, evt_next;
	logic [1:0]  evt_en_reg, evt_en_next;
	// bus state
	logic        wait_reg, wait_next;
	logic [31:0] rdata_reg, rdata_next;
	// output flops
	logic        cirq_reg, cirq_next;
	logic        eirq_reg, eirq_next;
	logic        usech_reg, usech_next;
	logic [3:0]  chan_reg, chan_next;
	logic        cap_reg, cap_next;
	logic        negp_reg, negp_next;
	logic        posp_reg, posp_next;

	logic        cmp_sync;
	logic        req;
	logic        commit_wr;
	logic [7:0]  idx;
	logic [7:0]  wbyte;
	logic        match;
	logic        toggle;

	// decode a byte address into a register index
	function automatic logic [7:0] acc_index(input logic [9:0] a);
		acc_index = a[9:2];
	endfunction : acc_index

	// synchronised comparator output
	acc_sync u_sync (
		.clk      (clk),
		.sys_rst  (sys_rst),
		.async_in (comparator_raw),
		.sync_out (cmp_sync)
	);

	assign req       = avs_read | avs_write;
	assign commit_wr = avs_write & ~wait_reg;
	assign idx       = acc_index(avs_address);
	assign wbyte     = avs_writedata[7:0];

	// edge detection against the previous sample
	always_comb begin
		toggle = cmp_sync ^ prev_reg;
		unique case (ctrl_reg[acc_pkg::ACC_EDGE_HI_BIT:0])
			acc_pkg::ACC_MODE_TOGGLE:  match = toggle;
			acc_pkg::ACC_MODE_RESV:    match = 1'b0;
			acc_pkg::ACC_MODE_FALLING: match = toggle & ~cmp_sync;
			acc_pkg::ACC_MODE_RISING:  match = toggle & cmp_sync;
		endcase
	end

	// bus handshake: one wait cycle, then answer
	always_comb begin
		wait_next  = ~(req & wait_reg);
		rdata_next = rdata_reg;
		if (req & wait_reg) begin
			rdata_next = 32'h0000_0000;
			unique case (idx)
				acc_pkg::ACC_IDX_CTRL_STATUS: begin
					rdata_next[7:0] = ctrl_reg;
					rdata_next[acc_pkg::ACC_OUTPUT_BIT] = cmp_sync;
					rdata_next[acc_pkg::ACC_FLAG_BIT] = flag_reg;
				end
				acc_pkg::ACC_IDX_CONV_CTRL_B:
					rdata_next[7:0] = convb_reg;
				acc_pkg::ACC_IDX_PIN_DISABLE:
					rdata_next[7:0] = pins_reg;
				acc_pkg::ACC_IDX_EVT_STATUS:
					rdata_next[1:0] = evt_reg;
				acc_pkg::ACC_IDX_EVT_ENABLE:
					rdata_next[1:0] = evt_en_reg;
				default:
					rdata_next = 32'h0000_0000;
			endcase
		end
	end

	// software-written registers
	always_comb begin
		ctrl_next   = ctrl_reg;
		convb_next  = convb_reg;
		pins_next   = pins_reg;
		evt_en_next = evt_en_reg;
		if (commit_wr) begin
			unique case (idx)
				acc_pkg::ACC_IDX_CTRL_STATUS:
					ctrl_next = wbyte;
				acc_pkg::ACC_IDX_CONV_CTRL_B:
					convb_next = wbyte & acc_pkg::ACC_CONV_B_MASK;
				acc_pkg::ACC_IDX_PIN_DISABLE:
					pins_next = wbyte;
				acc_pkg::ACC_IDX_EVT_ENABLE:
					evt_en_next = wbyte[1:0];
				default:
					ctrl_next = ctrl_reg;
			endcase
		end
		// output and flag bits are not stored here
		ctrl_next[acc_pkg::ACC_OUTPUT_BIT] = 1'b0;
		ctrl_next[acc_pkg::ACC_FLAG_BIT]   = 1'b0;
	end

	// event flag and sticky event status; set wins over clear
	always_comb begin
		logic fclr;
		logic [1:0] eclr;
		logic [1:0] eset;
		fclr = irq_vector_ack | (commit_wr
			& (idx == acc_pkg::ACC_IDX_CTRL_STATUS)
			& wbyte[acc_pkg::ACC_FLAG_BIT]);
		eclr = (commit_wr & (idx == acc_pkg::ACC_IDX_EVT_CLEAR))
			? wbyte[1:0] : 2'h0;
		eset = {toggle, match};
		flag_next = match | (flag_reg & ~fclr);
		evt_next  = eset | (evt_reg & ~eclr);
		prev_next = cmp_sync;
	end

	// registered outputs
	always_comb begin
		cirq_next = flag_reg & ctrl_reg[acc_pkg::ACC_IRQ_EN_BIT]
			& global_irq_enable;
		eirq_next = |(evt_reg & evt_en_reg);
		usech_next = convb_reg[acc_pkg::ACC_MUX_EN_BIT]
			& ~converter_on;
		chan_next = usech_next
			? {convb_reg[acc_pkg::ACC_CHAN_HI_BIT], channel_select_low}
			: 4'h0;
		cap_next = cmp_sync
			& ctrl_reg[acc_pkg::ACC_CAPTURE_BIT];
		negp_next = negative_pin_raw
			& ~pins_reg[acc_pkg::ACC_NEG_OFF_BIT];
		posp_next = positive_pin_raw
			& ~pins_reg[acc_pkg::ACC_POS_OFF_BIT];
	end

	// register all state
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			ctrl_reg   <= acc_pkg::ACC_RST_CTRL;
			convb_reg  <= acc_pkg::ACC_RST_CONVB;
			pins_reg   <= acc_pkg::ACC_RST_PINS;
			flag_reg   <= 1'b0;
			prev_reg   <= 1'b0;
			evt_reg    <= 2'h0;
			evt_en_reg <= 2'h0;
			wait_reg   <= 1'b1;
			rdata_reg  <= 32'h0000_0000;
			cirq_reg   <= 1'b0;
			eirq_reg   <= 1'b0;
			usech_reg  <= 1'b0;
			chan_reg   <= 4'h0;
			cap_reg    <= 1'b0;
			negp_reg   <= 1'b0;
			posp_reg   <= 1'b0;
		end else begin
			ctrl_reg   <= ctrl_next;
			convb_reg  <= convb_next;
			pins_reg   <= pins_next;
			flag_reg   <= flag_next;
			prev_reg   <= prev_next;
			evt_reg    <= evt_next;
			evt_en_reg <= evt_en_next;
			wait_reg   <= wait_next;
			rdata_reg  <= rdata_next;
			cirq_reg   <= cirq_next;
			eirq_reg   <= eirq_next;
			usech_reg  <= usech_next;
			chan_reg   <= chan_next;
			cap_reg    <= cap_next;
			negp_reg   <= negp_next;
			posp_reg   <= posp_next;
		end
	end

	// drive ports
	assign avs_readdata            = rdata_reg;
	assign avs_waitrequest         = wait_reg;
	assign comparator_power_off    = ctrl_reg[acc_pkg::ACC_POWER_OFF_BIT];
	assign bandgap_positive_select = ctrl_reg[acc_pkg::ACC_BANDGAP_BIT];
	assign capture_route_active    = ctrl_reg[acc_pkg::ACC_CAPTURE_BIT];
	assign negative_pin_input_off  = pins_reg[acc_pkg::ACC_NEG_OFF_BIT];
	assign positive_pin_input_off  = pins_reg[acc_pkg::ACC_POS_OFF_BIT];
	assign neg_use_channel         = usech_reg;
	assign neg_channel             = chan_reg;
	assign capture_source          = cap_reg;
	assign negative_pin_port_bit   = negp_reg;
	assign positive_pin_port_bit   = posp_reg;
	assign comparator_irq          = cirq_reg;
	assign event_irq               = eirq_reg;

	// checks share one clock and are off during reset
	default clocking acc_cb @(posedge clk); endclocking
	default disable iff (sys_rst);
	a_chan_select: assert property (
		(convb_reg[6] && !converter_on) |=>
		(neg_use_channel && neg_channel == {$past(convb_reg[3]),
			$past(channel_select_low)}))
		else $error("channel select wrong");
	a_pin_select: assert property (
		(!convb_reg[6] || converter_on) |=> !neg_use_channel)
		else $error("dedicated pin not used");
	a_power_write: assert property (
		(commit_wr && idx == acc_pkg::ACC_IDX_CTRL_STATUS) |=>
		comparator_power_off == $past(avs_writedata[7]))
		else $error("power off bit not written");
	a_bandgap_sel: assert property (
		(commit_wr && idx == acc_pkg::ACC_IDX_CTRL_STATUS) |=>
		bandgap_positive_select == $past(avs_writedata[6]))
		else $error("bandgap bit not written");
	a_out_latency: assert property (
		$rose(comparator_raw) ##1 comparator_raw |-> ##1 cmp_sync)
		else $error("output sync latency wrong");
	a_flag_set: assert property (
		match |=> flag_reg)
		else $error("event flag not set");
	a_flag_ack: assert property (
		(irq_vector_ack && !match) |=> !flag_reg)
		else $error("event flag not cleared by vector");
	a_irq_level: assert property (
		comparator_irq == $past(flag_reg && ctrl_reg[3] && global_irq_enable))
		else $error("comparator request wrong");
	a_mode_reserved: assert property (
		(ctrl_reg[1:0] == acc_pkg::ACC_MODE_RESV) |-> !match)
		else $error("reserved mode fired");
	a_capture_off: assert property (
		!ctrl_reg[2] |=> !capture_source)
		else $error("capture route leaked");
	a_pin_masked: assert property (
		pins_reg[1] |=> !negative_pin_port_bit)
		else $error("negative pin not masked");
	a_convb_zero: assert property (
		(convb_reg & ~acc_pkg::ACC_CONV_B_MASK) == 8'h00)
		else $error("reserved bits of conv b set");
	a_toggle_both: assert property (
		(ctrl_reg[1:0] == acc_pkg::ACC_MODE_TOGGLE && cmp_sync != prev_reg)
		|=> flag_reg)
		else $error("toggle edge missed");
endmodule : acc_top

// >>> acc_pkg.sv
// constants and register layout of the comparator control logic
package acc_pkg;
	// register indices; byte address is four times the index
	localparam logic [7:0] ACC_IDX_CTRL_STATUS = 8'h50;
	localparam logic [7:0] ACC_IDX_CONV_CTRL_B = 8'h7b;
	localparam logic [7:0] ACC_IDX_PIN_DISABLE = 8'h7f;
	localparam logic [7:0] ACC_IDX_EVT_STATUS  = 8'h80;
	localparam logic [7:0] ACC_IDX_EVT_CLEAR   = 8'h81;
	localparam logic [7:0] ACC_IDX_EVT_ENABLE  = 8'h82;
	localparam int         ACC_ADDR_W          = 10;
	localparam int         ACC_DATA_W          = 32;

	// control and status register fields
	localparam int ACC_POWER_OFF_BIT = 7;
	localparam int ACC_BANDGAP_BIT   = 6;
	localparam int ACC_OUTPUT_BIT    = 5;
	localparam int ACC_FLAG_BIT      = 4;
	localparam int ACC_IRQ_EN_BIT    = 3;
	localparam int ACC_CAPTURE_BIT   = 2;
	localparam int ACC_EDGE_HI_BIT   = 1;
	localparam int ACC_EDGE_LO_BIT   = 0;

	// converter control b fields
	localparam int           ACC_MUX_EN_BIT  = 6;
	localparam int           ACC_CHAN_HI_BIT = 3;
	localparam logic [7:0]   ACC_CONV_B_MASK = 8'h4f;

	// pin input disable fields
	localparam int ACC_NEG_OFF_BIT = 1;
	localparam int ACC_POS_OFF_BIT = 0;

	// event status bits
	localparam int ACC_EVT_MATCH  = 0;
	localparam int ACC_EVT_TOGGLE = 1;
	localparam int ACC_EVT_W      = 2;

	// edge mode codes
	localparam logic [1:0] ACC_MODE_TOGGLE  = 2'h0;
	localparam logic [1:0] ACC_MODE_RESV    = 2'h1;
	localparam logic [1:0] ACC_MODE_FALLING = 2'h2;
	localparam logic [1:0] ACC_MODE_RISING  = 2'h3;

	// reset values
	localparam logic [7:0] ACC_RST_CTRL  = 8'h00;
	localparam logic [7:0] ACC_RST_CONVB = 8'h00;
	localparam logic [7:0] ACC_RST_PINS  = 8'h00;
endpackage : acc_pkg

// >>> acc_sync.sv
// two flip-flop synchroniser for the comparator output
`timescale 1ns/1ps
module acc_sync (
	// clock and reset
	input  wire logic clk,
	input  wire logic sys_rst,
	// data
	input  wire logic async_in,
	output logic      sync_out
);
	logic meta_reg;
	logic meta_next;
	logic sync_reg;
	logic sync_next;

	// next values; first stage feeds only the second
	always_comb begin
		meta_next = async_in;
		sync_next = meta_reg;
	end

	// register the two stages
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			meta_reg <= 1'b0;
			sync_reg <= 1'b0;
		end else begin
			meta_reg <= meta_next;
			sync_reg <= sync_next;
		end
	end

	assign sync_out = sync_reg;
endmodule : acc_sync

// >>> acc_comp_model.sv
// behavioural analog comparator core with its input selection
`timescale 1ns/1ps
module acc_comp_model #(
	parameter logic [15:0] BANDGAP_MV = 16'h044c,
	parameter logic [15:0] CHAN_STEP  = 16'h0064
) (
	// selection from the block
	input  wire logic        power_off,
	input  wire logic        bandgap_sel,
	input  wire logic        neg_use_channel,
	input  wire logic [3:0]  neg_channel,
	// analog levels in millivolts
	input  wire logic [15:0] pos_pin_mv,
	input  wire logic [15:0] neg_pin_mv,
	// comparator result
	output logic             result
);
	int pos_v;
	int neg_v;

	// channel n sits at n steps, so the chosen channel shows in the result
	always_comb begin
		pos_v = bandgap_sel ? int'(BANDGAP_MV) : int'(pos_pin_mv);
		neg_v = neg_use_channel ? int'(CHAN_STEP) * int'(neg_channel)
			: int'(neg_pin_mv);
		result = !power_off && (pos_v > neg_v);
	end
endmodule : acc_comp_model

// >>> acc_top_tb.sv
// self-checking testbench of the comparator control logic
`timescale 1ns/1ps
module acc_top_tb;
	localparam logic [9:0]  A_CS = {acc_pkg::ACC_IDX_CTRL_STATUS, 2'b00};
	localparam logic [9:0]  A_CB = {acc_pkg::ACC_IDX_CONV_CTRL_B, 2'b00};
	localparam logic [9:0]  A_PN = {acc_pkg::ACC_IDX_PIN_DISABLE, 2'b00};
	localparam logic [9:0]  A_ES = {acc_pkg::ACC_IDX_EVT_STATUS, 2'b00};
	localparam logic [9:0]  A_EC = {acc_pkg::ACC_IDX_EVT_CLEAR, 2'b00};
	localparam logic [9:0]  A_EE = {acc_pkg::ACC_IDX_EVT_ENABLE, 2'b00};
	localparam logic [15:0] HI   = 16'h0258;
	localparam logic [15:0] LO   = 16'h0190;
	logic        clk = 1'b0;
	logic        sys_rst = 1'b1;
	logic [9:0]  avs_address = 10'h000;
	logic        avs_read = 1'b0;
	logic        avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0000_0000;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	logic        converter_on = 1'b0;
	logic [2:0]  channel_select_low = 3'h0;
	logic        comparator_raw;
	logic        comparator_power_off, bandgap_positive_select;
	logic        neg_use_channel;
	logic [3:0]  neg_channel;
	logic        negative_pin_raw = 1'b0, positive_pin_raw = 1'b0;
	logic        negative_pin_input_off, positive_pin_input_off;
	logic        negative_pin_port_bit, positive_pin_port_bit;
	logic        capture_source, capture_route_active;
	logic        global_irq_enable = 1'b0, irq_vector_ack = 1'b0;
	logic        comparator_irq, event_irq;
	logic [15:0] pos_mv = LO;
	logic [15:0] neg_mv = 16'h01f4;
	logic [1:0]  mode;
	int          fail_count = 0;
	int          total_checks = 0;

	// clock
	always #4 clk = ~clk;

	acc_top dut_u (.clk(clk), .sys_rst(sys_rst), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .converter_on(converter_on),
		.channel_select_low(channel_select_low),
		.comparator_raw(comparator_raw),
		.comparator_power_off(comparator_power_off),
		.bandgap_positive_select(bandgap_positive_select),
		.neg_use_channel(neg_use_channel), .neg_channel(neg_channel),
		.negative_pin_raw(negative_pin_raw),
		.positive_pin_raw(positive_pin_raw),
		.negative_pin_input_off(negative_pin_input_off),
		.positive_pin_input_off(positive_pin_input_off),
		.negative_pin_port_bit(negative_pin_port_bit),
		.positive_pin_port_bit(positive_pin_port_bit),
		.capture_source(capture_source),
		.capture_route_active(capture_route_active),
		.global_irq_enable(global_irq_enable),
		.irq_vector_ack(irq_vector_ack),
		.comparator_irq(comparator_irq), .event_irq(event_irq));

	// far side: analog core
	acc_comp_model model_u (.power_off(comparator_power_off),
		.bandgap_sel(bandgap_positive_select),
		.neg_use_channel(neg_use_channel), .neg_channel(neg_channel),
		.pos_pin_mv(pos_mv), .neg_pin_mv(neg_mv), .result(comparator_raw));

	task automatic final_report;
		if (fail_count == 0 && total_checks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : final_report

	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		total_checks++;
		if (g !== e) begin
			fail_count++;
			$display("FAIL %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	// one avalon access, held until waitrequest is seen low
	task automatic bus(input logic w, input logic [9:0] a,
		input logic [7:0] d, output logic [31:0] q);
		int n;
		n = 0;
		@(posedge clk);
		avs_address <= a;
		avs_write <= w;
		avs_read <= !w;
		avs_writedata <= {24'h00_0000, d};
		// waitrequest and read data are taken at the edge itself
		do begin
			@(posedge clk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 20);
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		if (avs_waitrequest !== 1'b0) begin
			fail_count++;
			final_report();
		end
	endtask : bus

	task automatic wr(input logic [9:0] a, input logic [7:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask : wr

	task automatic rd(input string nm, input logic [9:0] a,
		input logic [7:0] e);
		logic [31:0] q;
		bus(1'b0, a, 8'h00, q);
		chk(nm, {24'h00_0000, e}, q);
	endtask : rd

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask : cyc

	// main sequence
	initial begin
		cyc(8);
		sys_rst <= 1'b0;
		rd("cs", A_CS, 8'h00);
		rd("convb", A_CB, 8'h00);
		rd("pins", A_PN, 8'h00);
		rd("unmapped", 10'h3fc, 8'h00);
		wr(A_CB, 8'hff);
		rd("convb", A_CB, 8'h4f);
		wr(A_CB, 8'h00);
		// every edge mode with a rise and a fall, interrupt kept off
		for (int m = 0; m < 4; m++) begin
			mode = 2'(m);
			wr(A_CS, {6'h04, mode});
			pos_mv <= HI;
			cyc(5);
			rd("rise", A_CS, {3'h1, mode == 2'h0 || mode == 2'h3,
				2'h0, mode});
			wr(A_CS, {6'h04, mode});
			pos_mv <= LO;
			cyc(5);
			rd("fall", A_CS, {3'h0, mode == 2'h0 || mode == 2'h2,
				2'h0, mode});
		end
		rd("evt", A_ES, 8'h03);
		wr(A_EC, 8'h03);
		rd("evt", A_ES, 8'h00);
		rd("evclr", A_EC, 8'h00);
		// interrupt paths
		wr(A_EE, 8'h01);
		wr(A_CS, 8'h1b);
		global_irq_enable <= 1'b1;
		pos_mv <= HI;
		cyc(5);
		chk("cirq", 32'h0000_0001, 32'(comparator_irq));
		chk("eirq", 32'h0000_0001, 32'(event_irq));
		chk("caps", 32'h0000_0000, 32'(capture_source));
		global_irq_enable <= 1'b0;
		cyc(2);
		chk("cirq", 32'h0000_0000, 32'(comparator_irq));
		wr(A_CS, 8'h0b);
		rd("w0", A_CS, 8'h3b);
		global_irq_enable <= 1'b1;
		irq_vector_ack <= 1'b1;
		cyc(1);
		irq_vector_ack <= 1'b0;
		cyc(2);
		chk("cirq", 32'h0000_0000, 32'(comparator_irq));
		rd("ack", A_CS, 8'h2b);
		wr(A_EC, 8'h03);
		cyc(2);
		chk("eirq", 32'h0000_0000, 32'(event_irq));
		wr(A_CS, 8'h03);
		pos_mv <= LO;
		// bandgap, capture route, power off
		wr(A_CS, 8'h47);
		cyc(5);
		chk("bg", 32'h0000_0001, 32'(bandgap_positive_select));
		chk("capr", 32'h0000_0001, 32'(capture_route_active));
		chk("caps", 32'h0000_0001, 32'(capture_source));
		rd("bgcs", A_CS, 8'h77);
		wr(A_CS, 8'h80);
		cyc(5);
		chk("poff", 32'h0000_0001, 32'(comparator_power_off));
		chk("caps", 32'h0000_0000, 32'(capture_source));
		rd("off", A_CS, 8'h90);
		wr(A_CS, 8'h10);
		cyc(5);
		rd("on", A_CS, 8'h00);
		// pin input disables
		negative_pin_raw <= 1'b1;
		positive_pin_raw <= 1'b1;
		wr(A_PN, 8'h02);
		cyc(2);
		chk("noff", 32'h0000_0001, 32'(negative_pin_input_off));
		chk("nport", 32'h0000_0000, 32'(negative_pin_port_bit));
		chk("pport", 32'h0000_0001, 32'(positive_pin_port_bit));
		wr(A_PN, 8'h01);
		cyc(2);
		chk("nport", 32'h0000_0001, 32'(negative_pin_port_bit));
		chk("pport", 32'h0000_0000, 32'(positive_pin_port_bit));
		chk("poff", 32'h0000_0001, 32'(positive_pin_input_off));
		chk("noff", 32'h0000_0000, 32'(negative_pin_input_off));
		rd("pins", A_PN, 8'h01);
		// negative input selection over all sixteen channels
		for (int n = 0; n < 16; n++) begin
			channel_select_low <= 3'(n);
			wr(A_CB, {4'h4, n[3], 3'h0});
			cyc(2);
			chk("use", 32'h0000_0001, 32'(neg_use_channel));
			chk("chan", 32'(n), 32'(neg_channel));
		end
		converter_on <= 1'b1;
		cyc(2);
		chk("use", 32'h0000_0000, 32'(neg_use_channel));
		converter_on <= 1'b0;
		wr(A_CB, 8'h08);
		cyc(2);
		chk("use", 32'h0000_0000, 32'(neg_use_channel));
		final_report();
	end
endmodule : acc_top_tb
